// *** dv/offset_gain_trim_bank_test.sv ***
/* Testbench for the trim bank: register traffic, fuse load, gain selection
   and the corrected sample path. Assumes no partner; the bench drives all. */
`timescale 1ns/1ps
`include "offset_gain_trim_regs.vh"
module offset_gain_trim_bank_test;
  reg         hclk, hresetn, hwrite, fuse_valid, sample_valid, sample_input_b, rd_ph;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, x, rq[$], sq[$], v[0:5];
  reg  [15:0] fuse_offset;
  reg  [39:0] fuse_gain;
  reg  [11:0] sample_in;
  reg  [14:0] single_gain_other;
  wire        hreadyout, hresp, corr_valid_r;
  wire [31:0] hrdata;
  wire [11:0] corr_sample_r;
  wire [4:0]  gain_a0_r, gain_a1_r, gain_b0_r, gain_b1_r;
  int         n_errors, compares, i, m;
  localparam [11:0] CT = {`IDX_TRIM_CTRL, 2'h0};
  offset_gain_trim_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fuse_valid(fuse_valid),
    .fuse_offset(fuse_offset), .fuse_gain(fuse_gain), .sample_valid(sample_valid),
    .sample_input_b(sample_input_b), .sample_in(sample_in), .corr_valid_r(corr_valid_r),
    .corr_sample_r(corr_sample_r), .single_gain_other(single_gain_other),
    .gain_a0_r(gain_a0_r), .gain_a1_r(gain_a1_r), .gain_b0_r(gain_b0_r), .gain_b1_r(gain_b1_r));
  function [31:0] xs(input [31:0] a);
    xs = a ^ (a << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [11:0] ad(input int k);
    ad = k ? {`IDX_GAIN_A0_DUAL, 2'h0} + 4 * (k - 1) : {`IDX_OFFSET_CORE_B, 2'h0};
  endfunction
  // The offset is signed and the sum clips at the sample range.
  function [11:0] cor(input [11:0] s, input [11:0] o, input on);
    int t;
    t = $signed(s) + (on ? $signed(o) : 0);
    cor = t > 2047 ? 12'h7ff : t < -2048 ? 12'h800 : t[11:0];
  endfunction
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0; hwdata <= d; rd_ph <= !w;
    if (!w) rq.push_back(d);
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task smp(input b, input [11:0] s, input on);
    sample_valid <= 1'b1; sample_input_b <= b; sample_in <= s;
    sq.push_back(cor(s, v[0][11:0], on && b));
    @(posedge hclk);
  endtask
  task summarize;
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) chk("hrdata", hrdata, rq.pop_front());
    if (corr_valid_r) chk("corr_sample_r", corr_sample_r, sq.pop_front());
  end
  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    #200000 n_errors++;
    summarize;
  end
  initial begin
    x = 55341; hresetn = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0; rd_ph = 0;
    fuse_valid = 0; fuse_offset = 0; fuse_gain = 0; sample_valid = 0; sample_input_b = 0;
    sample_in = 0; single_gain_other = 0; n_errors = 0; compares = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // zero after reset, unmapped reads zero too.
    for (i = 0; i < 6; i++) bus(0, ad(i), 0);
    bus(0, CT, 0);
    bus(0, 12'hd3c, 0);
    x = xs(x);
    fuse_offset <= x[31:16]; fuse_gain <= {x[7:0], x}; fuse_valid <= 1'b1;
    @(posedge hclk);
    fuse_valid <= 1'b0;
    for (i = 0; i < 6; i++) bus(0, ad(i), i ? fuse_gain[8*i-8+:8] : fuse_offset);
    bus(0, CT, 32'h100);
    // reserved bits stored, upper bits dropped.
    for (i = 0; i < 6; i++) begin
      x = xs(x);
      v[i] = x & (i ? 32'hff : 32'hffff);
      bus(1, ad(i), x);
      bus(0, ad(i), v[i]);
    end
    // mode picks the gain set, offset in both modes.
    for (m = 0; m < 3; m++) begin
      single_gain_other <= x[14:0];
      bus(1, CT, {m[0], m != 2});
      repeat (2) @(posedge hclk);
      chk("gain_a0_r", gain_a0_r, m[0] ? v[5][4:0] : v[1][4:0]);
      chk("gain_a1_r", gain_a1_r, m[0] ? single_gain_other[4:0] : v[2][4:0]);
      chk("gain_b0_r", gain_b0_r, m[0] ? single_gain_other[9:5] : v[3][4:0]);
      chk("gain_b1_r", gain_b1_r, m[0] ? single_gain_other[14:10] : v[4][4:0]);
      for (i = 0; i < 8; i++) begin
        x = xs(x);
        smp(x[12], x[11:0], m != 2);
      end
      smp(1'b1, 12'h7ff, m != 2);
      smp(1'b1, 12'h800, m != 2);
      sample_valid <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    summarize;
  end
endmodule // offset_gain_trim_bank_test

// *** dv/offset_gain_trim_checker.sv ***
/* Checker for the trim bank's bus answer, sample path and reset levels.
   Assumes it is bound to offset_gain_trim_bank, one clock, hresetn low. */
`timescale 1ns/1ps
module offset_gain_trim_checker #(
  parameter SAMPLE_W = 12
) (
  // Clock, reset and bus answer
  input wire                hclk,
  input wire                hresetn,
  input wire                hreadyout,
  input wire                hresp,
  // Sample path
  input wire                sample_valid,
  input wire                sample_input_b,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire                corr_valid_r,
  input wire [SAMPLE_W-1:0] corr_sample_r,
  // Bus request and read data
  input wire                hsel,
  input wire                hready,
  input wire [1:0]          htrans,
  input wire                hwrite,
  input wire [31:0]         hrdata,
  // Gain trims
  input wire [4:0]          gain_a0_r,
  input wire [4:0]          gain_b1_r
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Samples of the first input must bypass the offset adder.
  sequence s_plain; sample_valid && !sample_input_b; endsequence
  // Read data may only move at the edge that takes a read.
  sequence s_no_read; !(hsel && hready && htrans[1] && !hwrite); endsequence
  a_ready_always: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_hold: assert property (s_no_read |=> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_valid_lag: assert property ($past(hresetn) |-> corr_valid_r == $past(sample_valid))
    else $error("corr_valid_r lag wrong");
  a_plain_pass: assert property (s_plain |=> corr_sample_r == $past(sample_in))
    else $error("plain sample altered");
  a_reset_gain: assert property ($rose(hresetn) |-> {gain_a0_r, gain_b1_r} == 10'h0)
    else $error("gain not zero after reset");
endmodule // offset_gain_trim_checker

bind offset_gain_trim_bank offset_gain_trim_checker #(.SAMPLE_W(SAMPLE_W)) u_checker (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .sample_valid(sample_valid), .sample_input_b(sample_input_b), .sample_in(sample_in),
  .corr_valid_r(corr_valid_r), .corr_sample_r(corr_sample_r),
  .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
  .gain_a0_r(gain_a0_r), .gain_b1_r(gain_b1_r)
);

// *** logic/offset_gain_trim_bank.v ***
/*
  Calibration trim register bank for a dual-core sampling converter, with an
  AHB-Lite slave for software and trim outputs toward the converter datapath.
  Assumes fuse data, samples and mode inputs come from logic on hclk.
*/
// Overview of operation
// - Add offset to core B input B samples
// - One offset copy serves both channel modes
// - Offset loads from fuses, writable, reserved RW
// - Four dual-mode 5-bit fine-gain trims applied
// - Single mode takes core A bank0 own register
// - Gain trims RW, reset zero, fuse default
`timescale 1ns/1ps
`include "offset_gain_trim_regs.vh"

module offset_gain_trim_bank #(
  parameter SAMPLE_W = 12
) (
  // Clock and reset
  input  wire                hclk,
  input  wire                hresetn,
  // AHB-Lite slave
  input  wire                hsel,
  input  wire [31:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata,
  output reg                 hreadyout,
  output reg                 hresp,
  // Factory fuse defaults
  input  wire                fuse_valid,
  input  wire [15:0]         fuse_offset,
  input  wire [39:0]         fuse_gain,
  // Core B samples of either input
  input  wire                sample_valid,
  input  wire                sample_input_b,
  input  wire [SAMPLE_W-1:0] sample_in,
  output reg                 corr_valid_r,
  output reg  [SAMPLE_W-1:0] corr_sample_r,
  // Single-mode trims held outside this bank
  input  wire [14:0]         single_gain_other,
  // Gain trims toward the datapath
  output reg  [4:0]          gain_a0_r,
  output reg  [4:0]          gain_a1_r,
  output reg  [4:0]          gain_b0_r,
  output reg  [4:0]          gain_b1_r
);

  reg  [15:0] second_core_second_input_offset;
  reg  [7:0]  first_core_bank0_gain_trim;
  reg  [7:0]  first_core_bank1_gain_trim;
  reg  [7:0]  second_core_bank0_gain_trim;
  reg  [7:0]  second_core_bank1_gain_trim;
  reg  [7:0]  first_core_bank0_single_gain_reg;
  // The control word is a local addition: bit 0 enables calibration, bit 1 picks single mode.
  reg  [1:0]  ctrl_r;
  reg         fuse_done_r;
  reg         wr_pend_r;
  reg  [9:0]  wr_idx_r;

  reg  [15:0] offset_nxt;
  reg  [7:0]  ga0_nxt;
  reg  [7:0]  ga1_nxt;
  reg  [7:0]  gb0_nxt;
  reg  [7:0]  gb1_nxt;
  reg  [7:0]  gs0_nxt;
  reg  [1:0]  ctrl_nxt;
  reg  [31:0] rd_nxt;

  wire        fuse_load = fuse_valid & ~fuse_done_r;
  // Only the word index is decoded, so address bits above 11 alias; hsize is
  // not checked because every register is one whole word.
  wire        addr_ok   = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  wire [9:0]  addr_idx  = haddr[11:2];
  wire        fg_cal_en = ctrl_r[`CTRL_FG_CAL_BIT];
  wire        single_md = ctrl_r[`CTRL_SINGLE_BIT];

  always @* begin
    offset_nxt = second_core_second_input_offset;
    ga0_nxt    = first_core_bank0_gain_trim;
    ga1_nxt    = first_core_bank1_gain_trim;
    gb0_nxt    = second_core_bank0_gain_trim;
    gb1_nxt    = second_core_bank1_gain_trim;
    gs0_nxt    = first_core_bank0_single_gain_reg;
    ctrl_nxt   = ctrl_r;
    if (fuse_load) begin
      offset_nxt = fuse_offset;
      ga0_nxt    = fuse_gain[7:0];
      ga1_nxt    = fuse_gain[15:8];
      gb0_nxt    = fuse_gain[23:16];
      gb1_nxt    = fuse_gain[31:24];
      gs0_nxt    = fuse_gain[39:32];
    end
    // Software writes land after the fuse load so a user trim written in the same cycle wins over it.
    if (wr_pend_r) begin
      case (wr_idx_r)
        `IDX_OFFSET_CORE_B:  offset_nxt = hwdata[15:0];
        `IDX_GAIN_A0_DUAL:   ga0_nxt = hwdata[7:0];
        `IDX_GAIN_A1_DUAL:   ga1_nxt = hwdata[7:0];
        `IDX_GAIN_B0_DUAL:   gb0_nxt = hwdata[7:0];
        `IDX_GAIN_B1_DUAL:   gb1_nxt = hwdata[7:0];
        `IDX_GAIN_A0_SINGLE: gs0_nxt = hwdata[7:0];
        `IDX_TRIM_CTRL:      ctrl_nxt = hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Reads see the value being written in the same cycle, so a read right
  // behind a write to the same register returns the new value.
  always @* begin
    // Unmapped words and the bits above each register read as zero.
    rd_nxt = 32'h0000_0000;
    case (addr_idx)
      `IDX_OFFSET_CORE_B:  rd_nxt[15:0] = offset_nxt;
      `IDX_GAIN_A0_DUAL:   rd_nxt[7:0]  = ga0_nxt;
      `IDX_GAIN_A1_DUAL:   rd_nxt[7:0]  = ga1_nxt;
      `IDX_GAIN_B0_DUAL:   rd_nxt[7:0]  = gb0_nxt;
      `IDX_GAIN_B1_DUAL:   rd_nxt[7:0]  = gb1_nxt;
      `IDX_GAIN_A0_SINGLE: rd_nxt[7:0]  = gs0_nxt;
      `IDX_TRIM_CTRL: begin
        rd_nxt[1:0]                 = ctrl_nxt;
        rd_nxt[`CTRL_FUSE_DONE_BIT] = fuse_done_r | fuse_load;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_core_second_input_offset  <= `OFFSET_RESET;
      first_core_bank0_gain_trim       <= `GAIN_RESET;
      first_core_bank1_gain_trim       <= `GAIN_RESET;
      second_core_bank0_gain_trim      <= `GAIN_RESET;
      second_core_bank1_gain_trim      <= `GAIN_RESET;
      first_core_bank0_single_gain_reg <= `GAIN_RESET;
      ctrl_r      <= `CTRL_RESET;
      fuse_done_r <= 1'b0;
      wr_pend_r   <= 1'b0;
      wr_idx_r    <= 10'h000;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      second_core_second_input_offset  <= offset_nxt;
      first_core_bank0_gain_trim       <= ga0_nxt;
      first_core_bank1_gain_trim       <= ga1_nxt;
      second_core_bank0_gain_trim      <= gb0_nxt;
      second_core_bank1_gain_trim      <= gb1_nxt;
      first_core_bank0_single_gain_reg <= gs0_nxt;
      ctrl_r      <= ctrl_nxt;
      // The fuse load is taken once per reset, so a later strobe cannot
      // overwrite a trim that software has already written.
      fuse_done_r <= fuse_done_r | fuse_valid;
      // The write waits for its data phase, when hwdata is valid.
      wr_pend_r   <= addr_ok & hwrite;
      wr_idx_r    <= addr_idx;
      // No wait states: every transfer ends in its data phase with OKAY.
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // Datapath side: samples are registered once, which costs one cycle of
  // latency but keeps every output straight from a flip-flop.
  wire signed [SAMPLE_W:0] sum_w = $signed({sample_in[SAMPLE_W-1], sample_in})
                                 + $signed({{(SAMPLE_W-11){second_core_second_input_offset[11]}},
                                            second_core_second_input_offset[`OFFSET_MSB:0]});
  // Clipping keeps a large offset from wrapping a full-scale sample around.
  wire [SAMPLE_W-1:0] max_w = {1'b0, {(SAMPLE_W-1){1'b1}}};
  wire [SAMPLE_W-1:0] min_w = {1'b1, {(SAMPLE_W-1){1'b0}}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_valid_r  <= 1'b0;
      corr_sample_r <= {SAMPLE_W{1'b0}};
      gain_a0_r     <= 5'h00;
      gain_a1_r     <= 5'h00;
      gain_b0_r     <= 5'h00;
      gain_b1_r     <= 5'h00;
    end else begin
      corr_valid_r <= sample_valid;
      if (fg_cal_en && sample_input_b) begin
        if (sum_w[SAMPLE_W] != sum_w[SAMPLE_W-1]) begin
          corr_sample_r <= sum_w[SAMPLE_W] ? min_w : max_w;
        end else begin
          corr_sample_r <= sum_w[SAMPLE_W-1:0];
        end
      end else begin
        corr_sample_r <= sample_in;
      end
      if (single_md) begin
        gain_a0_r <= first_core_bank0_single_gain_reg[`GAIN_MSB:0];
        gain_a1_r <= single_gain_other[4:0];
        gain_b0_r <= single_gain_other[9:5];
        gain_b1_r <= single_gain_other[14:10];
      end else begin
        gain_a0_r <= first_core_bank0_gain_trim[`GAIN_MSB:0];
        gain_a1_r <= first_core_bank1_gain_trim[`GAIN_MSB:0];
        gain_b0_r <= second_core_bank0_gain_trim[`GAIN_MSB:0];
        gain_b1_r <= second_core_bank1_gain_trim[`GAIN_MSB:0];
      end
    end
  end

endmodule // offset_gain_trim_bank

// *** logic/offset_gain_trim_regs.vh ***
/*
  Register indices, field positions, reset values and bus constants for the
  offset and gain trim bank. Assumes it is included by name, once per file.
*/
`ifndef OFFSET_GAIN_TRIM_REGS_VH
`define OFFSET_GAIN_TRIM_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_OFFSET_CORE_B    10'h34e
`define IDX_GAIN_A0_DUAL     10'h350
`define IDX_GAIN_A1_DUAL     10'h351
`define IDX_GAIN_B0_DUAL     10'h352
`define IDX_GAIN_B1_DUAL     10'h353
`define IDX_GAIN_A0_SINGLE   10'h354
`define IDX_TRIM_CTRL        10'h360

// Field positions.
`define OFFSET_MSB           11
`define GAIN_MSB             4
`define CTRL_FG_CAL_BIT      0
`define CTRL_SINGLE_BIT      1
`define CTRL_FUSE_DONE_BIT   8

// Reset values.
`define OFFSET_RESET         16'h0000
`define GAIN_RESET           8'h00
`define CTRL_RESET           2'h0

// Bus constants.
`define HTRANS_NONSEQ_BIT    1

`endif
